// ### psram_lp_map.svh
// register map, field positions, control reset value and timings in nanoseconds of the low-power control block
`ifndef PSRAM_LP_MAP_SVH
`define PSRAM_LP_MAP_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define LP_CTRL_OFS 12'h000
`define LP_STATUS_OFS 12'h004
`define LP_LOST_OFS 12'h008
`define LP_RCOUNT_OFS 12'h00C

// ****************************************************************
// control field positions and reset value
// ****************************************************************
`define LP_CTRL_EN_BIT 0
`define LP_CTRL_TOP_BIT 1
`define LP_CTRL_SEL_LSB 2
`define LP_CTRL_DRV_LSB 4
`define LP_CTRL_RESET 6'h00

// ****************************************************************
// status field positions
// ****************************************************************
`define LP_STAT_EXEC_BIT 0
`define LP_STAT_COLD_BIT 1
`define LP_STAT_HELD_BIT 2
`define LP_STAT_LOST_LSB 4

// ****************************************************************
// timing
// ****************************************************************
`define LP_PCLK_NS 40
`define LP_STROBE_MAX_NS 500
`define LP_REFRESH_HOT_NS 7800
`define LP_REFRESH_COLD_NS 31200

`endif

// ### psram_lp_pkg.sv
// types shared by the low-power control block
`default_nettype none
package psram_lp_pkg;

  // retained region size selection
  typedef enum logic [1:0] {
    RET_FULL = 2'h0,
    RET_THREE_Q = 2'h1,
    RET_HALF = 2'h2,
    RET_ONE_Q = 2'h3
  } ret_sel_e;

  // output driver strength selection
  typedef enum logic [1:0] {
    DRV_FULL = 2'h0,
    DRV_HALF = 2'h1,
    DRV_QUARTER = 2'h2
  } drv_sel_e;

  // operating state of the refresh control
  typedef enum logic [1:0] {
    ST_NORMAL = 2'b01,
    ST_PAR_EXEC = 2'b10
  } lp_state_e;

endpackage
`default_nettype wire

// ### psram_lp_if.sv
// carrier between the control core, the refresh timer and the strobe watcher
`default_nettype none
interface psram_lp_if;
  logic ce;
  logic cold;
  logic tick;
  logic strobe_n;
  logic strobe_held;

  modport tmr (input ce, input cold, output tick);
  modport stb (input ce, input strobe_n, output strobe_held);
  modport ctl (output ce, output cold, output strobe_n, input tick, input strobe_held);
endinterface
`default_nettype wire

// ### refresh_timer.sv
// self-refresh interval timer with a temperature-dependent period
`include "psram_lp_map.svh"
`default_nettype none
module refresh_timer #(
  parameter int HOT_CYC = `LP_REFRESH_HOT_NS / `LP_PCLK_NS,
  parameter int COLD_CYC = `LP_REFRESH_COLD_NS / `LP_PCLK_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  psram_lp_if.tmr lp
);
  logic [15:0] cnt_r;
  logic tick_r;

  // reload with the long period when cool, the worst-case period otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else if (lp.ce) begin
      tick_r <= (cnt_r == 16'h0000);
      if (cnt_r == 16'h0000) begin
        cnt_r <= lp.cold ? 16'(COLD_CYC - 1) : 16'(HOT_CYC - 1);
      end else begin
        cnt_r <= cnt_r - 16'h0001;
      end
    end
  end

  assign lp.tick = tick_r & lp.ce;
endmodule
`default_nettype wire

// ### strobe_watch.sv
// measures how long the mode strobe stays low
`include "psram_lp_map.svh"
`default_nettype none
module strobe_watch #(
  parameter int HOLD_CYC = `LP_STROBE_MAX_NS / `LP_PCLK_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  psram_lp_if.stb lp
);
  logic [7:0] low_cnt_r;

  // count low cycles, saturate at the limit, restart when the pin rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_r <= 8'h00;
    end else if (lp.ce) begin
      if (lp.strobe_n) begin
        low_cnt_r <= 8'h00;
      end else if (low_cnt_r != 8'(HOLD_CYC)) begin
        low_cnt_r <= low_cnt_r + 8'h01;
      end
    end
  end

  // a low pulse shorter than the limit never counts as a mode request
  assign lp.strobe_held = (low_cnt_r == 8'(HOLD_CYC));
endmodule
`default_nettype wire

// ### psram_lp_ctrl.sv
// low-power refresh control: partial array retention, self-refresh rate, drive strength
`include "psram_lp_map.svh"
`default_nettype none
module psram_lp_ctrl #(
  parameter int ADDR_W = 23,
  parameter int ROW_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins and array side
  input wire logic mode_set_strobe_n,
  input wire logic temp_below_40,
  input wire logic access_valid,
  input wire logic [ADDR_W-1:0] access_addr,
  output logic access_retained,
  output logic par_executed,
  output logic refresh_req,
  output logic [ROW_W+1:0] refresh_row,
  output logic [1:0] drive_strength
);

  // ****************************************************************
  // helpers
  // ****************************************************************

  // true when a block lies inside the retained region
  function automatic logic block_kept(input logic [1:0] sel, input logic top, input logic [1:0] blk);
    logic [2:0] n;
    n = 3'h4;
    case (sel)
      psram_lp_pkg::RET_FULL: n = 3'h4;
      psram_lp_pkg::RET_THREE_Q: n = 3'h3;
      psram_lp_pkg::RET_HALF: n = 3'h2;
      psram_lp_pkg::RET_ONE_Q: n = 3'h1;
      default: n = 3'h4;
    endcase
    // bottom keeps blocks below n, top keeps blocks from 4-n upward
    if (top) begin
      block_kept = ({1'b0, blk} >= (3'h4 - n));
    end else begin
      block_kept = ({1'b0, blk} < n);
    end
  endfunction

  // register offset match
  function automatic logic ofs_is(input logic [11:0] a, input logic [11:0] ofs);
    ofs_is = (a == ofs);
  endfunction

  // ****************************************************************
  // sub-blocks
  // ****************************************************************
  psram_lp_if lp ();

  assign lp.ce = clk_en;
  assign lp.cold = temp_below_40;
  assign lp.strobe_n = mode_set_strobe_n;

  refresh_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .lp(lp)
  );

  strobe_watch u_strobe (
    .pclk(pclk),
    .presetn(presetn),
    .lp(lp)
  );

  // ****************************************************************
  // register file
  // ****************************************************************
  logic ctrl_en_r;
  logic ctrl_top_r;
  logic [1:0] ctrl_sel_r;
  logic [1:0] ctrl_drv_r;
  logic [3:0] lost_r;
  logic [3:0] lost_nxt;
  logic [15:0] rcount_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic [5:0] ctrl_rst;
  logic [31:0] status_word;

  assign ctrl_rst = `LP_CTRL_RESET;

  // transfer completes in its first access cycle unless clock enable is low
  assign pready = clk_en;
  assign wr_en = psel & penable & pwrite & clk_en;
  assign rd_en = psel & penable & ~pwrite & clk_en;
  assign mapped = ofs_is(paddr, `LP_CTRL_OFS) | ofs_is(paddr, `LP_STATUS_OFS) |
                  ofs_is(paddr, `LP_LOST_OFS) | ofs_is(paddr, `LP_RCOUNT_OFS);

  // control register: enable, anchor, size and drive strength
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en_r <= ctrl_rst[`LP_CTRL_EN_BIT];
      ctrl_top_r <= ctrl_rst[`LP_CTRL_TOP_BIT];
      ctrl_sel_r <= ctrl_rst[`LP_CTRL_SEL_LSB +: 2];
      ctrl_drv_r <= ctrl_rst[`LP_CTRL_DRV_LSB +: 2];
    end else if (wr_en && ofs_is(paddr, `LP_CTRL_OFS)) begin
      ctrl_en_r <= pwdata[`LP_CTRL_EN_BIT];
      ctrl_top_r <= pwdata[`LP_CTRL_TOP_BIT];
      ctrl_sel_r <= pwdata[`LP_CTRL_SEL_LSB +: 2];
      ctrl_drv_r <= pwdata[`LP_CTRL_DRV_LSB +: 2];
    end
  end

  // ****************************************************************
  // operating state
  // ****************************************************************
  psram_lp_pkg::lp_state_e state_r;
  psram_lp_pkg::lp_state_e state_nxt;

  // retention starts only when enabled and the strobe stays low past the limit
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      psram_lp_pkg::ST_NORMAL: begin
        // the pin must still be low: a pulse that ends at the limit is an ordinary access
        if (ctrl_en_r && lp.strobe_held && !mode_set_strobe_n) begin
          state_nxt = psram_lp_pkg::ST_PAR_EXEC;
        end
      end
      psram_lp_pkg::ST_PAR_EXEC: begin
        if (mode_set_strobe_n) begin
          state_nxt = psram_lp_pkg::ST_NORMAL;
        end
      end
      default: state_nxt = psram_lp_pkg::ST_NORMAL;
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= psram_lp_pkg::ST_NORMAL;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // refresh walker
  // ****************************************************************
  logic [ROW_W+1:0] walk_r;
  logic walk_kept;
  logic exec;
  logic refresh_req_r;
  logic [ROW_W+1:0] refresh_row_r;

  assign exec = (state_r == psram_lp_pkg::ST_PAR_EXEC);

  // top two bits of the walk index name one of four equal blocks
  assign walk_kept = !exec || block_kept(ctrl_sel_r, ctrl_top_r, walk_r[ROW_W +: 2]);

  // step one row per tick; rows of dropped blocks get no refresh
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      walk_r <= '0;
      refresh_req_r <= 1'b0;
      refresh_row_r <= '0;
    end else if (clk_en) begin
      refresh_req_r <= lp.tick & walk_kept;
      if (lp.tick) begin
        refresh_row_r <= walk_r;
        walk_r <= walk_r + 1'b1;
      end
    end
  end

  // count issued refreshes for software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rcount_r <= 16'h0000;
    end else if (clk_en && refresh_req_r) begin
      rcount_r <= rcount_r + 16'h0001;
    end
  end

  // ****************************************************************
  // lost-contents flags
  // ****************************************************************

  // a skipped refresh marks its block lost; write one clears, a new loss wins
  always_comb begin
    lost_nxt = lost_r;
    if (wr_en && ofs_is(paddr, `LP_LOST_OFS)) begin
      lost_nxt = lost_r & ~pwdata[3:0];
    end
    if (lp.tick && !walk_kept) begin
      lost_nxt[walk_r[ROW_W +: 2]] = 1'b1;
    end
  end

  // lost flags register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lost_r <= 4'h0;
    end else if (clk_en) begin
      lost_r <= lost_nxt;
    end
  end

  // ****************************************************************
  // access qualification
  // ****************************************************************
  logic access_retained_r;

  // a normal access anywhere is fine; flag whether its block is still retained
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      access_retained_r <= 1'b0;
    end else if (clk_en && access_valid) begin
      access_retained_r <= ~lost_r[access_addr[ADDR_W-1 -: 2]];
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`LP_STAT_EXEC_BIT] = exec;
    status_word[`LP_STAT_COLD_BIT] = temp_below_40;
    status_word[`LP_STAT_HELD_BIT] = lp.strobe_held;
    status_word[`LP_STAT_LOST_LSB +: 4] = lost_r;
  end

  // read data and error register, unmapped offsets answer with an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (clk_en) begin
      pslverr_r <= psel & ~penable & ~mapped;
      prdata_r <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        if (ofs_is(paddr, `LP_CTRL_OFS)) begin
          prdata_r <= {26'h0000000, ctrl_drv_r, ctrl_sel_r, ctrl_top_r, ctrl_en_r};
        end else if (ofs_is(paddr, `LP_STATUS_OFS)) begin
          prdata_r <= status_word;
        end else if (ofs_is(paddr, `LP_LOST_OFS)) begin
          prdata_r <= {28'h0000000, lost_r};
        end else if (ofs_is(paddr, `LP_RCOUNT_OFS)) begin
          prdata_r <= {16'h0000, rcount_r};
        end
      end
    end
  end

  assign prdata = rd_en ? prdata_r : 32'h0000_0000;
  assign pslverr = psel & penable & pslverr_r;

  // ****************************************************************
  // outputs
  // ****************************************************************
  logic [1:0] drive_r;

  // reserved drive code falls back to full drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_r <= psram_lp_pkg::DRV_FULL;
    end else if (clk_en) begin
      if (ctrl_drv_r == 2'h3) begin
        drive_r <= psram_lp_pkg::DRV_FULL;
      end else begin
        drive_r <= ctrl_drv_r;
      end
    end
  end

  assign drive_strength = drive_r;
  assign par_executed = exec;
  assign refresh_req = refresh_req_r;
  assign refresh_row = refresh_row_r;
  assign access_retained = access_retained_r;

endmodule
`default_nettype wire

// ### psram_host_model.sv
// host-side model that drives the mode strobe pin low for a commanded number of cycles
`default_nettype none
module psram_host_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [15:0] low_len,
  output logic busy,
  output logic mode_set_strobe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] cnt_r;
  // load the hold length on a request, then count it down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 16'h0000;
    end else if (go) begin
      cnt_r <= low_len;
    end else if (cnt_r != 16'h0000) begin
      cnt_r <= cnt_r - 16'h0001;
    end
  end
  // pin released high as soon as the count runs out
  assign mode_set_strobe_n = (cnt_r == 16'h0000);
  assign busy = (cnt_r != 16'h0000);
endmodule
`default_nettype wire

// ### psram_lp_ctrl_checker.sv
// assertion checker bound to the low-power refresh control block
`default_nettype none
module psram_lp_ctrl_checker #(
  parameter int ADDR_W = 23,
  parameter int ROW_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mode_set_strobe_n,
  input wire logic temp_below_40,
  input wire logic access_valid,
  input wire logic [ADDR_W-1:0] access_addr,
  input wire logic access_retained,
  input wire logic par_executed,
  input wire logic refresh_req,
  input wire logic [ROW_W+1:0] refresh_row,
  input wire logic [1:0] drive_strength
);
  logic [31:0] low_cnt_r;
  logic [31:0] gap_cnt_r;
  logic [31:0] hot_run_r;
  logic [31:0] cold_run_r;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // run lengths of strobe low, refresh gap and steady temperature; frozen like the block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_r <= 32'h0;
      gap_cnt_r <= 32'h0;
      hot_run_r <= 32'h0;
      cold_run_r <= 32'h0;
    end else if (clk_en) begin
      low_cnt_r <= mode_set_strobe_n ? 32'h0 : low_cnt_r + 32'h1;
      gap_cnt_r <= refresh_req ? 32'h0 : gap_cnt_r + 32'h1;
      hot_run_r <= (temp_below_40 || par_executed) ? 32'h0 : hot_run_r + 32'h1;
      cold_run_r <= (!temp_below_40 || par_executed) ? 32'h0 : cold_run_r + 32'h1;
    end
  end
  // entry and exit steps of partial retention
  sequence s_entry;
    $rose(par_executed);
  endsequence
  sequence s_release;
    par_executed && mode_set_strobe_n && clk_en;
  endsequence
  property p_pready;
    pready == clk_en;
  endproperty
  a_pready: assert property (p_pready) else $error("pready does not follow clk_en");
  property p_rd_idle;
    !(psel && penable && !pwrite && clk_en) |-> prdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read access");
  property p_enter;
    s_entry |-> low_cnt_r >= 32'hD;
  endproperty
  a_enter: assert property (p_enter) else $error("retention entered on short strobe");
  property p_stay;
    par_executed && !mode_set_strobe_n |=> par_executed;
  endproperty
  a_stay: assert property (p_stay) else $error("retention left while strobe low");
  property p_exit;
    s_release |=> !par_executed;
  endproperty
  a_exit: assert property (p_exit) else $error("retention kept after strobe high");
  property p_drive;
    drive_strength != 2'h3;
  endproperty
  a_drive: assert property (p_drive) else $error("undefined drive strength");
  property p_hot_gap;
    refresh_req && clk_en && hot_run_r >= 32'h190 |-> gap_cnt_r inside {[190:200]};
  endproperty
  a_hot_gap: assert property (p_hot_gap) else $error("hot refresh gap wrong");
  property p_cold_gap;
    refresh_req && clk_en && cold_run_r >= 32'h640 |-> gap_cnt_r inside {[770:790]};
  endproperty
  a_cold_gap: assert property (p_cold_gap) else $error("cold refresh gap wrong");
endmodule
bind psram_lp_ctrl psram_lp_ctrl_checker #(.ADDR_W(ADDR_W), .ROW_W(ROW_W)) i_chk (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .mode_set_strobe_n(mode_set_strobe_n), .temp_below_40(temp_below_40),
  .access_valid(access_valid), .access_addr(access_addr), .access_retained(access_retained),
  .par_executed(par_executed), .refresh_req(refresh_req), .refresh_row(refresh_row),
  .drive_strength(drive_strength));
`default_nettype wire

// ### psram_lp_ctrl_bench.sv
// self-checking bench of the low-power refresh control block
`include "psram_lp_map.svh"
`default_nettype none
module psram_lp_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, temp_below_40 = 1'b0, access_valid = 1'b0, go = 1'b0, seen;
  logic busy, strobe_n, access_retained, par_executed, refresh_req, pready, pslverr, err_b;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [22:0] access_addr = 23'h0;
  logic [15:0] low_len = 16'h0000;
  logic [9:0] refresh_row;
  logic [1:0] drive_strength;
  int err_count = 0, compares = 0, n;
  always #20 pclk = ~pclk;
  psram_host_model i_host (.pclk(pclk), .presetn(presetn), .go(go), .low_len(low_len),
    .busy(busy), .mode_set_strobe_n(strobe_n));
  psram_lp_ctrl i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mode_set_strobe_n(strobe_n),
    .temp_below_40(temp_below_40), .access_valid(access_valid), .access_addr(access_addr),
    .access_retained(access_retained), .par_executed(par_executed),
    .refresh_req(refresh_req), .refresh_row(refresh_row), .drive_strength(drive_strength));
  task automatic check(input string what, input logic [31:0] seen_v, input logic [31:0] exp);
    compares++;
    if (seen_v !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen_v);
    end
  endtask
  // one apb transfer: setup, then access held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err_b = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // strobe held low for len edges; checks entry and the exit one edge after release
  task automatic strobe(input logic [15:0] len, input logic exp);
    @(posedge pclk);
    go <= 1'b1;
    low_len <= len;
    seen = 1'b0;
    @(posedge pclk);
    go <= 1'b0;
    do begin
      @(posedge pclk);
      seen = seen | par_executed;
    end while (busy);
    check("executed", seen, exp);
    @(posedge pclk);
    check("exit", par_executed, 1'b0);
  endtask
  task automatic acc(input logic [22:0] a);
    @(posedge pclk);
    access_valid <= 1'b1;
    access_addr <= a;
    @(posedge pclk);
    access_valid <= 1'b0;
    @(posedge pclk);
    check("retained", access_retained, 1'b1);
  endtask
  task automatic end_sim;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    end_sim;
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `LP_CTRL_OFS, 32'h0);
    check("ctrl reset", rd, 32'(`LP_CTRL_RESET));
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped err", err_b, 1'b1);
    for (int d = 0; d < 4; d++) begin
      apb(1'b1, `LP_CTRL_OFS, 32'(d << `LP_CTRL_DRV_LSB));
      repeat (2) @(posedge pclk);
      check("drive", drive_strength, (d == 3) ? 2'h0 : 2'(d));
    end
    apb(1'b1, `LP_CTRL_OFS, 32'h4);
    strobe(16'd40, 1'b0);
    apb(1'b1, `LP_CTRL_OFS, 32'h5);
    strobe(16'd12, 1'b0);
    strobe(16'd13, 1'b1);
    // every size and anchor: kept blocks never lost, edge addresses retained
    for (int s = 0; s < 4; s++) begin
      for (int t = 0; t < 2; t++) begin
        apb(1'b1, `LP_LOST_OFS, 32'hF);
        apb(1'b1, `LP_CTRL_OFS, 32'({s[1:0], t[0], 1'b1}));
        strobe(16'd600, 1'b1);
        apb(1'b0, `LP_LOST_OFS, 32'h0);
        check("lost kept", rd[3:0] & (t ? (4'hF << s) : (4'hF >> s)), 4'h0);
        acc(t ? {s[1:0], 21'h0} : 23'h0);
        acc(t ? 23'h7FFFFF : {2'(3 - s), 21'h1FFFFF});
      end
    end
    @(posedge pclk);
    clk_en <= 1'b0;
    @(posedge pclk);
    check("frozen", pready, 1'b0);
    clk_en <= 1'b1;
    for (int c = 0; c < 2; c++) begin
      temp_below_40 <= c[0];
      repeat (3) begin
        n = 0;
        do begin
          @(posedge pclk);
          n++;
        end while (refresh_req !== 1'b1);
      end
      check("gap", n, c ? `LP_REFRESH_COLD_NS / `LP_PCLK_NS :
        `LP_REFRESH_HOT_NS / `LP_PCLK_NS);
    end
    end_sim;
  end
endmodule
`default_nettype wire
